//--- apu_top.sv
/*
 * Accumulator pointer unit: the active accumulator select register and
 * its step control register, reached over classic Wishbone, stepping the
 * pointer after each arithmetic or logical operation of the core.
 * Assumes step request inputs are one-cycle pulses on the same clock and
 * a Wishbone master that holds its request until it sees ack.
 */
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps

module apu_top
    import apu_pkg::*;
#(
    parameter int NUM_ACC = APU_NUM_ACC_DEF
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire apu_wb_req_t wb_req,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic op_done,
    input wire logic move_to_ptr,
    output logic [APU_PTR_W-1:0] active_acc
);

    // ************************************************************
    // State and decode
    // ************************************************************
    apu_state_t state_r;
    apu_state_t state_nxt;
    logic [APU_PTR_W-1:0] ptr_stepped;
    logic bus_new;
    logic bus_wr;
    logic hit_ptr;
    logic hit_ctl;
    logic step_due;
    logic clear_req;
    logic [7:0] wr_byte;
    logic [3:0] held_mask;
    logic [2:0] wrap_held_mask;

    // A new bus request is one that has not been answered yet
    assign bus_new = wb_req.cyc && wb_req.stb && !state_r.ack;
    assign bus_wr = bus_new && wb_req.we && wb_req.sel[0];
    assign hit_ptr = wb_req.adr[APU_ADR_W-1:2] == APU_IDX_POINTER;
    assign hit_ctl = wb_req.adr[APU_ADR_W-1:2] == APU_IDX_CONTROL;
    assign wr_byte = wb_req.dat[7:0];

    // An operation or a move into the pointer both ask for a step
    assign step_due = op_done || move_to_ptr;
    assign clear_req = bus_wr && hit_ctl && wr_byte[APU_CTL_CLR_BIT];

    // Bits that an eight-accumulator build ties to zero
    assign held_mask = (NUM_ACC == 8) ? 4'h7 : 4'hF;
    assign wrap_held_mask = (NUM_ACC == 8) ? 3'h3 : 3'h7;

    // ************************************************************
    // Step arithmetic
    // ************************************************************
    apu_stepper #(
        .NUM_ACC(NUM_ACC)
    ) u_stepper (
        .ptr(state_r.ptr),
        .wrap(state_r.wrap),
        .dir(state_r.dir),
        .ptr_stepped(ptr_stepped)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    // Pointer priority: clear, then bus write, then automatic step
    always_comb begin
        state_nxt = state_r;
        // One-cycle ack for every new request, mapped or not
        state_nxt.ack = bus_new;
        state_nxt.rdata = APU_RDATA_RST;
        if (bus_new && !wb_req.we) begin
            if (hit_ptr) begin
                // Upper four bits and bus bits above read zero
                state_nxt.rdata[APU_PTR_W-1:0] = state_r.ptr;
            end else if (hit_ctl) begin
                // Clear bit reads zero, bits 3 to 5 read zero
                state_nxt.rdata[2:0] = state_r.wrap;
                state_nxt.rdata[APU_CTL_DIR_BIT] = state_r.dir;
            end
        end
        // Automatic step only when a wrap size is selected
        if (step_due && state_r.wrap != APU_WRAP_OFF) begin
            state_nxt.ptr = ptr_stepped;
        end
        if (bus_wr && hit_ptr) begin
            // Only the selection bits are stored
            state_nxt.ptr = wr_byte[APU_PTR_W-1:0] & held_mask;
        end
        if (bus_wr && hit_ctl) begin
            state_nxt.wrap = wr_byte[2:0] & wrap_held_mask;
            state_nxt.dir = wr_byte[APU_CTL_DIR_BIT];
        end
        if (clear_req) begin
            // The clear is never stored, so it reads back as zero
            state_nxt.ptr = APU_PTR_RST;
        end
        state_nxt.ptr = state_nxt.ptr & held_mask;
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Synchronous reset clears both registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= APU_STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // All straight from the state register
    assign wb_ack_o = state_r.ack;
    assign wb_dat_o = state_r.rdata;
    assign active_acc = state_r.ptr;

    // ************************************************************
    // Checks
    // ************************************************************
    // Helper: a read request of each register, answered in the next cycle
    logic rd_ptr_req;
    logic rd_ctl_req;
    logic step_free;

    // Reads are checked against the state seen when they were taken
    assign rd_ptr_req = bus_new && !wb_req.we && hit_ptr;
    assign rd_ctl_req = bus_new && !wb_req.we && hit_ctl;
    // A step with no bus write to either register in the same cycle
    assign step_free = step_due && !(bus_wr && (hit_ptr || hit_ctl));

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    chk_read_shows_ptr: assert property (
        rd_ptr_req |=> wb_dat_o[APU_PTR_W-1:0] == $past(active_acc)
    ) else $error("pointer read does not match active select");

    chk_bit3_held: assert property (
        (NUM_ACC == 8) |-> active_acc[3] == 1'b0
    ) else $error("pointer bit 3 set on eight-accumulator build");

    chk_ptr_upper_zero: assert property (
        rd_ptr_req |=> wb_dat_o[31:APU_PTR_W] == 28'h000_0000
    ) else $error("reserved pointer bits read nonzero");

    chk_reset_clears: assert property (
        $rose(reset_n) |-> active_acc == APU_PTR_RST && !wb_ack_o && state_r.wrap == APU_WRAP_RST
            && state_r.dir == APU_DIR_RST ##1 !wb_ack_o
    ) else $error("registers not cleared by reset");

    chk_ack_one_cycle: assert property (
        bus_new |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("ack not a single cycle one edge after request");

    chk_no_step_off: assert property (
        step_free && state_r.wrap == APU_WRAP_OFF |=> $stable(active_acc)
    ) else $error("pointer stepped with wrap size off");

    chk_step_up_two: assert property (
        step_free && state_r.wrap == APU_WRAP_2 && !state_r.dir
        |=> active_acc == {$past(active_acc[3:1]), ~$past(active_acc[0])}
    ) else $error("modulo 2 up step wrong");

    chk_wrap8_down: assert property (
        step_free && state_r.wrap == APU_WRAP_8 && state_r.dir && active_acc[2:0] == 3'h0
        |=> active_acc[2:0] == 3'h7 ##0 active_acc[3] == $past(active_acc[3])
    ) else $error("modulo 8 down step did not wrap to 7");

    chk_wrap16_up: assert property (
        step_free && state_r.wrap[2] && !state_r.dir && active_acc == 4'hF && NUM_ACC == 16
        |=> active_acc == 4'h0
    ) else $error("modulo 16 up step did not wrap to 0");

    chk_clear_wins: assert property (
        clear_req |=> active_acc == APU_PTR_RST
    ) else $error("clear did not override the step");

    chk_ctl_reserved: assert property (
        rd_ctl_req |=> wb_dat_o[5:3] == 3'h0 && wb_dat_o[31:7] == 25'h000_0000
    ) else $error("reserved control bits read nonzero");

    // Control read shows the stored wrap code and direction
    chk_ctl_read: assert property (
        rd_ctl_req
        |=> wb_dat_o[2:0] == $past(state_r.wrap) && wb_dat_o[6] == $past(state_r.dir)
    ) else $error("control read does not match stored fields");

    // Data bus rests at zero outside the ack cycle
    chk_dat_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000
    ) else $error("read data not zero outside ack");

    // A pointer write lands whole, bit 3 only on the full build
    chk_ptr_write: assert property (
        bus_wr && hit_ptr
        |=> active_acc[2:0] == $past(wr_byte[2:0])
            && active_acc[3] == (NUM_ACC == 16 && $past(wr_byte[3]))
    ) else $error("pointer write not stored");

    // A control write stores wrap code and direction
    chk_ctl_write: assert property (
        bus_wr && hit_ctl
        |=> state_r.wrap[1:0] == $past(wr_byte[1:0])
            && state_r.dir == $past(wr_byte[APU_CTL_DIR_BIT])
    ) else $error("control write not stored");

    // Small build never holds the top wrap bit
    chk_wrap_top_held: assert property (
        (NUM_ACC == 8) |-> !state_r.wrap[2]
    ) else $error("wrap top bit set on eight-accumulator build");

    // Modulo 4 up: low two bits count, upper two stay
    chk_wrap4_up: assert property (
        step_free && state_r.wrap == APU_WRAP_4 && !state_r.dir
        |=> active_acc[1:0] == 2'($past(active_acc[1:0]) + 2'h1)
            && active_acc[3:2] == $past(active_acc[3:2])
    ) else $error("modulo 4 up step wrong");

    // Modulo 8 up wraps from 7 to 0, bit 3 untouched
    chk_wrap8_up: assert property (
        step_free && state_r.wrap == APU_WRAP_8 && !state_r.dir && active_acc[2:0] == 3'h7
        |=> active_acc[2:0] == 3'h0 && active_acc[3] == $past(active_acc[3])
    ) else $error("modulo 8 up step did not wrap to 0");

    // Modulo 16 down wraps from 0 to 15
    chk_wrap16_down: assert property (
        step_free && state_r.wrap[2] && state_r.dir && active_acc == 4'h0 && NUM_ACC == 16
        |=> active_acc == 4'hF
    ) else $error("modulo 16 down step did not wrap to 15");

    // A move into the pointer steps it when stepping is on
    chk_move_steps: assert property (
        move_to_ptr && step_free && state_r.wrap != APU_WRAP_OFF
        |=> active_acc != $past(active_acc)
    ) else $error("move into pointer did not step");

    // Without a step or a write the pointer holds
    chk_idle_holds: assert property (
        !step_due && !bus_wr |=> $stable(active_acc)
    ) else $error("pointer changed with no step and no write");

    // A write without byte lane 0 stores nothing
    chk_sel_ignored: assert property (
        bus_new && wb_req.we && !wb_req.sel[0] && !step_due
        |=> $stable(active_acc) && $stable(state_r.wrap) && $stable(state_r.dir)
    ) else $error("write without byte lane 0 changed a register");

    // Unmapped reads return zero
    chk_unmapped_read: assert property (
        bus_new && !wb_req.we && !hit_ptr && !hit_ctl |=> wb_dat_o == 32'h0000_0000
    ) else $error("unmapped read returned nonzero");

endmodule // apu_top

//--- apu_pkg.sv
/*
 * Constants, field layouts and carrier types for the accumulator pointer
 * unit: register indices, control field positions, wrap codes and masks.
 * Assumes a 32-bit classic Wishbone register bus and a core that pulses
 * one-cycle step requests on the same clock.
 */
package apu_pkg;

    // ************************************************************
    // Register map (indices; byte address is four times the index)
    // ************************************************************
    localparam int APU_ADR_W = 8;
    localparam logic [5:0] APU_IDX_POINTER = 6'h00;  // accumulator_pointer
    localparam logic [5:0] APU_IDX_CONTROL = 6'h01;  // pointer_control

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int APU_PTR_W = 4;
    localparam int APU_CTL_WRAP_LSB = 0;
    localparam int APU_CTL_DIR_BIT = 6;
    localparam int APU_CTL_CLR_BIT = 7;
    localparam logic [3:0] APU_PTR_RST = 4'h0;
    localparam logic [2:0] APU_WRAP_RST = 3'h0;
    localparam logic APU_DIR_RST = 1'b0;
    localparam logic [31:0] APU_RDATA_RST = 32'h0000_0000;
    localparam int APU_NUM_ACC_DEF = 16;

    // ************************************************************
    // Wrap size codes and the pointer bits each one lets move
    // ************************************************************
    localparam logic [2:0] APU_WRAP_OFF = 3'h0;
    localparam logic [2:0] APU_WRAP_2 = 3'h1;
    localparam logic [2:0] APU_WRAP_4 = 3'h2;
    localparam logic [2:0] APU_WRAP_8 = 3'h3;
    localparam logic [2:0] APU_WRAP_16 = 3'h4;
    localparam logic [3:0] APU_MASK_OFF = 4'h0;
    localparam logic [3:0] APU_MASK_2 = 4'h1;
    localparam logic [3:0] APU_MASK_4 = 4'h3;
    localparam logic [3:0] APU_MASK_8 = 4'h7;
    localparam logic [3:0] APU_MASK_16 = 4'hF;

    // ************************************************************
    // Carrier types
    // ************************************************************
    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [APU_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } apu_wb_req_t;

    // Whole state of the unit
    typedef struct packed {
        logic [APU_PTR_W-1:0] ptr;
        logic [2:0] wrap;
        logic dir;
        logic ack;
        logic [31:0] rdata;
    } apu_state_t;

    localparam apu_state_t APU_STATE_RST = '{
        ptr: APU_PTR_RST,
        wrap: APU_WRAP_RST,
        dir: APU_DIR_RST,
        ack: 1'b0,
        rdata: APU_RDATA_RST
    };

endpackage

//--- apu_stepper.sv
/*
 * Next-value logic for one automatic pointer step: moves only the bits
 * inside the selected wrap size, up or down, wrapping at the ends.
 * Assumes the caller decides when a step is due and registers the result.
 */
`timescale 1ns/10ps

module apu_stepper
    import apu_pkg::*;
#(
    parameter int NUM_ACC = APU_NUM_ACC_DEF
) (
    input wire logic [APU_PTR_W-1:0] ptr,
    input wire logic [2:0] wrap,
    input wire logic dir,
    output logic [APU_PTR_W-1:0] ptr_stepped
);

    logic [3:0] mask;
    logic [3:0] moved;

    // ************************************************************
    // Wrap mask and stepped value
    // ************************************************************
    // Code to mask; any code with the top bit set means sixteen on the 16-accumulator build, else only the low two bits are decoded
    always_comb begin
        mask = APU_MASK_OFF;
        if (wrap[2] && NUM_ACC == 16) begin
            mask = APU_MASK_16;
        end else begin
            unique case (wrap[1:0])
                APU_WRAP_OFF[1:0]: mask = APU_MASK_OFF;
                APU_WRAP_2[1:0]: mask = APU_MASK_2;
                APU_WRAP_4[1:0]: mask = APU_MASK_4;
                APU_WRAP_8[1:0]: mask = APU_MASK_8;
            endcase
        end
        // Up or down by one, truncated to the pointer width
        moved = dir ? 4'(ptr - 4'h1) : 4'(ptr + 4'h1);
        // Bits outside the wrap size keep their value
        ptr_stepped = (ptr & ~mask) | (moved & mask);
    end

endmodule // apu_stepper

//--- tb_top.sv
/*
 * Self-checking bench for apu_top: register access over classic Wishbone,
 * reserved bits, clear priority and random stepping for every wrap code.
 * Assumes apu_pkg is compiled first; runs a 16- and an 8-accumulator build.
 */
`timescale 1ns/10ps

module tb_top
    import apu_pkg::*;
;
    logic clock;
    logic reset_n;
    apu_wb_req_t wb_req;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic op_done;
    logic move_to_ptr;
    logic [3:0] active_acc;
    int error_cnt;
    int n_checks;
    logic [3:0] ep;
    logic [7:0] ctl;
    logic [31:0] rd;
    logic [3:0] acc8;
    logic [3:0] ep8;
    logic [3:0] sel_v;

    apu_top #(.NUM_ACC(16)) i_apu_top (
        .clock(clock),
        .reset_n(reset_n),
        .wb_req(wb_req),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .op_done(op_done),
        .move_to_ptr(move_to_ptr),
        .active_acc(active_acc)
    );

    // Eight-accumulator build on the same stimulus
    if (1) begin : g_acc8
        apu_top #(.NUM_ACC(8)) i_apu_top (
            .clock(clock),
            .reset_n(reset_n),
            .wb_req(wb_req),
            .wb_ack_o(),
            .wb_dat_o(),
            .op_done(op_done),
            .move_to_ptr(move_to_ptr),
            .active_acc(acc8)
        );
    end

    // Clock of 20 ns
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One classic cycle; a step may be pulsed at the request edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                           input logic pulse, output logic [31:0] data);
        int i;
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel_v, dat: 32'(dat)};
        op_done <= pulse;
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            op_done <= 1'b0;
            if (wb_ack_o === 1'b1)
                break;
        end
        data = wb_dat_o;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        if (i == 8) begin
            error_cnt++;
            test_done();
        end
    endtask

    // Expected pointer after one step: only bits inside the wrap move
    function automatic logic [3:0] stepped(input logic [3:0] p, input logic [7:0] c);
        logic [3:0] m;
        m = c[2] ? 4'hF : (4'h1 << c[1:0]) - 4'h1;
        return (p & ~m) | ((c[6] ? p - 4'h1 : p + 4'h1) & m);
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        wb_req = '0;
        op_done = 1'b0;
        move_to_ptr = 1'b0;
        sel_v = 4'h1;
        reset_n = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        void'($urandom(28));
        repeat (16) @(posedge clock);
        check(32'(active_acc), 32'h0000_0000);
        reset_n <= 1'b1;
        wb_xfer(1'b0, 8'h00, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0000);
        wb_xfer(1'b0, 8'h04, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0000);
        $display("test reset values done");
        // Reserved bits, unmapped index, clear against a same-cycle step
        wb_xfer(1'b1, 8'h00, 8'hFF, 1'b0, rd);
        wb_xfer(1'b0, 8'h00, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_000F);
        wb_xfer(1'b1, 8'h04, 8'h7C, 1'b0, rd);
        wb_xfer(1'b0, 8'h04, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0044);
        wb_xfer(1'b1, 8'h08, 8'h55, 1'b0, rd);
        wb_xfer(1'b0, 8'h08, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0000);
        wb_xfer(1'b1, 8'h04, 8'h81, 1'b1, rd);
        wb_xfer(1'b0, 8'h00, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0000);
        wb_xfer(1'b0, 8'h04, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0001);
        // Pointer write beats a step; control write lets it run on old settings
        wb_xfer(1'b1, 8'h00, 8'h06, 1'b1, rd);
        wb_xfer(1'b1, 8'h04, 8'h02, 1'b1, rd);
        sel_v = 4'h0;
        wb_xfer(1'b1, 8'h00, 8'h03, 1'b0, rd);
        sel_v = 4'h1;
        wb_xfer(1'b0, 8'h00, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0007);
        wb_xfer(1'b0, 8'h04, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0002);
        $display("test register access done");
        // Random step pulses for every wrap code, both directions
        for (int c = 0; c < 16; c++) begin
            ctl = {1'b0, c[3], 3'b000, c[2:0]};
            ep = 4'($urandom);
            ep8 = ep & 4'h7;
            wb_xfer(1'b1, 8'h00, {4'h0, ep}, 1'b0, rd);
            wb_xfer(1'b1, 8'h04, ctl, 1'b0, rd);
            for (int k = 0; k < 25; k++) begin
                @(posedge clock);
                check(32'(active_acc), 32'(ep));
                check(32'(acc8), 32'(ep8));
                if (op_done | move_to_ptr) begin
                    ep = stepped(ep, ctl);
                    ep8 = stepped(ep8, ctl & 8'hFB);
                end
                op_done <= (k < 24) && ($urandom_range(0, 1) == 1);
                move_to_ptr <= (k < 24) && ($urandom_range(0, 3) == 0);
            end
            wb_xfer(1'b0, 8'h00, 8'h00, 1'b0, rd);
            check(rd, 32'(ep));
        end
        $display("test stepping done");
        // Reset in mid-run clears both registers again
        wb_xfer(1'b1, 8'h00, 8'h0B, 1'b0, rd);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        check(32'(active_acc), 32'h0000_0000);
        check(32'(acc8), 32'h0000_0000);
        wb_xfer(1'b0, 8'h04, 8'h00, 1'b0, rd);
        check(rd, 32'h0000_0000);
        $display("test mid-run reset done");
        test_done();
    end
endmodule // tb_top
